// file: sysopt_regs.svh
// register offsets, field positions, reset values and timing counts for the option block
// assumes a 32-bit AHB-Lite slave with one aligned word per register
`ifndef SYSOPT_REGS_SVH
`define SYSOPT_REGS_SVH
`define OFS_STOP_CLOCK_OPTION 8'h00
`define OFS_SYSTEM_OPTION     8'h04
`define OFS_AWU_CONTROL       8'h08
`define OFS_STOP_STATUS       8'h0C
`define OFS_STOP_CONTROL      8'h10
// stop_clock_option fields
`define BIT_OSC_RUN_IN_STOP   0
`define BIT_RESET_PIN_ENABLE  1
// system_option fields
`define BIT_WATCHDOG_RATE_SEL 0
`define BIT_LOWVOLT_POWER_OFF 1
`define BIT_LOWVOLT_TRIP_SEL  2
`define BIT_SHORT_RECOVERY    3
`define BIT_STOP_ENABLE       4
`define BIT_WATCHDOG_DISABLE  5
// auto-wakeup control fields
`define BIT_WAKEUP_IRQ_EN     0
`define BIT_AWU_CLK_SEL       1
// stop control: write 1 to request stop entry
`define BIT_STOP_REQ          0
`define RST_STOP_CLOCK_OPTION 8'h00
`define RST_SYSTEM_OPTION     8'h00
`define RST_AWU_CONTROL       8'h00
// delays in quad-rate bus clock cycles
`define LONG_DELAY_CYCLES     4096
`define SHORT_DELAY_CYCLES    32
`endif

// file: sysopt_pkg.sv
// types for the system option block
// assumes sysopt_regs.svh is used alongside for numbers
package sysopt_pkg;
  typedef enum logic [1:0] {
    ST_POR_WAIT = 2'b00,
    ST_RUN      = 2'b01,
    ST_STOPPED  = 2'b10,
    ST_RECOVER  = 2'b11
  } stop_state_t;
endpackage

// file: system_option_config_bits.sv
// system option registers and stop-recovery sequencing behind an AHB-Lite slave
// assumes sys_clk is the quad-rate bus clock and rst is synchronous; por_n, lvi_reset and wakeup come from pins
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "sysopt_regs.svh"

// Function
// R01: the oscillator-in-stop bit keeps the half-rate clock source running in stop to feed auto-wakeup, else it stops.
// R02: the auto-wakeup period comes from the watchdog rate select combined with the auto-wakeup clock source.
// R03: the low-voltage power-off bit at one removes monitor power, at zero keeps it powered.
// R04: the trip select bit chooses 5 V trip points at one and 3 V trip points at zero.
// R05: only power-on reset clears the trip select bit; other resets leave it. The lowvolt_trip_select output is still driven to 0 while rst is high.
// R06: short recovery at one leaves stop after 32 quad-rate cycles, at zero after 4096.
// R07: a stop exit caused by low-voltage reset always uses the long delay.
// R08: after power-on reset a 4096 cycle stabilization delay is applied.
// R09: software picks short recovery only if 32 cycles exceed the monitor turn-on time.
// R10: stop enable at one lets stop run, at zero stop is an illegal opcode.
// R11: the watchdog disable bit at one disables the watchdog, at zero it stays enabled.
// R12: the wakeup interrupt enable is read-write, reset-cleared, and gates wakeup interrupt latching.
// R13: on stop exit the counter runs on the quad-rate clock and processor clocks stay off until the delay ends.
// R14: the external reset pin function exists only while the reset pin enable bit is set.
// R15: each configuration bit is a static level to the module it controls.
module system_option_config_bits
  import sysopt_pkg::*;
#(
  parameter int LONG_DELAY  = `LONG_DELAY_CYCLES,
  parameter int SHORT_DELAY = `SHORT_DELAY_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        por_n,
  input  wire logic        lvi_reset,
  input  wire logic        wakeup_event,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             osc_run_in_stop,
  output logic             half_rate_clk_en,
  output logic             awu_period_sel,
  output logic             awu_clk_sel,
  output logic             lowvolt_power_off,
  output logic             lowvolt_trip_select,
  output logic             stop_enable,
  output logic             illegal_stop,
  output logic             watchdog_disable,
  output logic             reset_pin_enable,
  output logic             wakeup_irq_req,
  output logic             core_clk_en
);
  initial begin
    if (LONG_DELAY < 2 || SHORT_DELAY < 1 || SHORT_DELAY >= LONG_DELAY || LONG_DELAY > 65535)
      $error("delay parameters out of range");
  end

  // pin inputs pass three flops; a change counts when stages two and three agree
  logic [2:0] por_sync_r, lvi_sync_r, wk_sync_r;
  logic       por_n_q_r, lvi_q_r, wk_q_r, wk_prev_r;
  always_ff @(posedge sys_clk) begin
    por_sync_r <= {por_sync_r[1:0], por_n};
    lvi_sync_r <= {lvi_sync_r[1:0], lvi_reset};
    wk_sync_r  <= {wk_sync_r[1:0], wakeup_event};
    if (por_sync_r[1] == por_sync_r[2]) por_n_q_r <= por_sync_r[2];
    if (lvi_sync_r[1] == lvi_sync_r[2]) lvi_q_r <= lvi_sync_r[2];
    if (wk_sync_r[1] == wk_sync_r[2]) wk_q_r <= wk_sync_r[2];
    wk_prev_r <= wk_q_r;
  end
  wire por_active = ~por_n_q_r;
  wire wake_rise  = wk_q_r & ~wk_prev_r;

  // bus address phase capture
  logic       wr_pend_r, rd_pend_r;
  logic [7:0] addr_r;
  wire        take = hsel & hready & htrans[1];
  // reads get one wait state so the registered read data lines up with the data phase
  wire        rd_take = take & ~hwrite;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= take & hwrite;
      rd_pend_r <= take & ~hwrite;
      if (take) addr_r <= haddr[7:0];
    end
  end
  wire wr_sco  = wr_pend_r & (addr_r == `OFS_STOP_CLOCK_OPTION);
  wire wr_so   = wr_pend_r & (addr_r == `OFS_SYSTEM_OPTION);
  wire wr_awu  = wr_pend_r & (addr_r == `OFS_AWU_CONTROL);
  wire wr_stop = wr_pend_r & (addr_r == `OFS_STOP_CONTROL);

  // configuration registers
  logic [7:0] sco_r, so_r, awu_r;
  logic       trip_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sco_r <= `RST_STOP_CLOCK_OPTION;
      so_r  <= `RST_SYSTEM_OPTION;
      awu_r <= `RST_AWU_CONTROL;
    end else begin
      if (wr_sco) sco_r <= hwdata[7:0];
      if (wr_so) so_r <= hwdata[7:0];
      if (wr_awu) awu_r <= hwdata[7:0];
    end
  end
  // trip select survives every reset but power-on
  always_ff @(posedge sys_clk) begin
    if (por_active) trip_r <= 1'b0; // R05
    else if (wr_so) trip_r <= hwdata[`BIT_LOWVOLT_TRIP_SEL];
  end

  // stop sequencing
  stop_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        lvi_exit_r;
  logic        stop_req_r;
  wire [15:0]  long_m1  = 16'(LONG_DELAY - 1);
  wire [15:0]  short_m1 = 16'(SHORT_DELAY - 1);
  wire         short_sel = so_r[`BIT_SHORT_RECOVERY] & ~lvi_exit_r; // R06 R07
  wire         stop_ok   = so_r[`BIT_STOP_ENABLE];
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_POR_WAIT: begin
        if (cnt_r == 16'h0000) st_nxt = ST_RUN; // R08
        else cnt_nxt = cnt_r - 16'h0001;
      end
      ST_RUN: begin
        if (stop_req_r && stop_ok) st_nxt = ST_STOPPED; // R10
      end
      ST_STOPPED: begin
        if (wake_rise || lvi_q_r) begin
          st_nxt  = ST_RECOVER;
          cnt_nxt = (short_sel && !lvi_q_r) ? short_m1 : long_m1; // R06 R07
        end
      end
      ST_RECOVER: begin
        if (cnt_r == 16'h0000) st_nxt = ST_RUN; // R13
        else cnt_nxt = cnt_r - 16'h0001;
      end
      default: st_nxt = ST_RUN;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (por_active) begin
      st_r  <= ST_POR_WAIT;
      cnt_r <= long_m1;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvi_exit_r <= 1'b0;
      stop_req_r <= 1'b0;
    end else begin
      lvi_exit_r <= (st_r == ST_STOPPED) ? lvi_q_r : lvi_exit_r & (st_r == ST_RECOVER);
      stop_req_r <= wr_stop & hwdata[`BIT_STOP_REQ] & (st_r == ST_RUN);
    end
  end

  // read data
  wire [7:0] stat = {5'h00, lvi_exit_r, st_r};
  wire [7:0] rd_mux = (addr_r == `OFS_STOP_CLOCK_OPTION) ? {sco_r[7:2], sco_r[1:0]} :
                      (addr_r == `OFS_SYSTEM_OPTION)     ? {so_r[7:3], trip_r, so_r[1:0]} :
                      (addr_r == `OFS_AWU_CONTROL)       ? awu_r :
                      (addr_r == `OFS_STOP_STATUS)       ? stat : 8'h00;

  // set wins over a clearing write in the same cycle
  wire       irq_set  = wake_rise & awu_r[`BIT_WAKEUP_IRQ_EN];
  wire       irq_clr  = wr_awu & ~hwdata[`BIT_WAKEUP_IRQ_EN];
  // power-on wait overrides the state register, so the clock gate must see it too
  wire       core_run = (st_nxt == ST_RUN) & ~por_active;

  // all outputs registered; option outputs are static levels, illegal_stop pulses for one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata              <= 32'h0000_0000;
      hreadyout           <= 1'b1;
      hresp               <= 1'b0;
      osc_run_in_stop     <= 1'b0;
      half_rate_clk_en    <= 1'b1;
      awu_period_sel      <= 1'b0;
      awu_clk_sel         <= 1'b0;
      lowvolt_power_off   <= 1'b0;
      lowvolt_trip_select <= 1'b0;
      stop_enable         <= 1'b0;
      illegal_stop        <= 1'b0;
      watchdog_disable    <= 1'b0;
      reset_pin_enable    <= 1'b0;
      wakeup_irq_req      <= 1'b0;
      core_clk_en         <= 1'b0;
    end else begin
      hrdata              <= rd_pend_r ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      hreadyout           <= ~rd_take;
      hresp               <= 1'b0;
      osc_run_in_stop     <= sco_r[`BIT_OSC_RUN_IN_STOP]; // R15
      half_rate_clk_en    <= (st_nxt != ST_STOPPED) | sco_r[`BIT_OSC_RUN_IN_STOP]; // R01
      awu_period_sel      <= so_r[`BIT_WATCHDOG_RATE_SEL]; // R02
      awu_clk_sel         <= awu_r[`BIT_AWU_CLK_SEL]; // R02
      lowvolt_power_off   <= so_r[`BIT_LOWVOLT_POWER_OFF]; // R03
      lowvolt_trip_select <= trip_r; // R04
      stop_enable         <= stop_ok; // R10
      illegal_stop        <= stop_req_r & ~stop_ok; // R10
      watchdog_disable    <= so_r[`BIT_WATCHDOG_DISABLE]; // R11
      reset_pin_enable    <= sco_r[`BIT_RESET_PIN_ENABLE]; // R14
      wakeup_irq_req      <= (wakeup_irq_req & ~irq_clr) | irq_set; // R12
      core_clk_en         <= core_run; // R13
    end
  end

  // checks: bus and read path
  read_wait_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
    (take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  read_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
    !rd_pend_r |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  // checks: power-on wait and recovery
  por_hold_a: assert property (@(posedge sys_clk) // R08
    por_active |=> st_r == ST_POR_WAIT && cnt_r == long_m1 && !core_clk_en)
    else $error("power-on wait not held");
  por_wait_a: assert property (@(posedge sys_clk) disable iff (rst) // R08
    (st_r == ST_POR_WAIT && cnt_r != 16'h0000) |=> !core_clk_en)
    else $error("core clock on during power-on wait");
  core_clk_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (st_r == ST_RECOVER && cnt_r != 16'h0000) |=> !core_clk_en)
    else $error("core clock on during recovery");
  recover_step_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (st_r == ST_RECOVER && cnt_r != 16'h0000 && !por_active) |=>
      st_r == ST_RECOVER && cnt_r == $past(cnt_r) - 16'h0001)
    else $error("recovery counter skipped");
  lvi_long_a: assert property (@(posedge sys_clk) disable iff (rst) // R07
    (st_r == ST_STOPPED && lvi_q_r && !por_active) |=> cnt_r == long_m1)
    else $error("lvi exit not long");
  lvi_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // R07
    (st_r == ST_STOPPED && lvi_q_r) |=> lvi_exit_r)
    else $error("lvi exit not flagged");
  short_exit_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
    (st_r == ST_STOPPED && wake_rise && !lvi_q_r && short_sel && !por_active) |=> cnt_r == short_m1)
    else $error("short delay wrong");

  // checks: trip select
  trip_keep_a: assert property (@(posedge sys_clk) // R05
    (rst && !por_active && !wr_so) |=> $stable(trip_r))
    else $error("trip cleared by reset");
  trip_por_a: assert property (@(posedge sys_clk) // R05
    por_active |=> !trip_r)
    else $error("trip kept through power-on");
  trip_write_a: assert property (@(posedge sys_clk) // R04
    (wr_so && !por_active) |=> trip_r == $past(hwdata[`BIT_LOWVOLT_TRIP_SEL]))
    else $error("trip bit not written");
  trip_out_a: assert property (@(posedge sys_clk) disable iff (rst) // R04
    1'b1 |=> lowvolt_trip_select == $past(trip_r))
    else $error("trip output stale");

  // checks: stop entry and clocks in stop
  stop_entry_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    (st_r == ST_RUN && stop_req_r && stop_ok && !por_active) |=> st_r == ST_STOPPED)
    else $error("stop not entered");
  stop_illegal_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    (stop_req_r && !stop_ok) |=> illegal_stop && st_r != ST_STOPPED)
    else $error("stop not refused");
  stop_en_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    1'b1 |=> stop_enable == $past(stop_ok))
    else $error("stop enable level");
  osc_stop_a: assert property (@(posedge sys_clk) disable iff (rst) // R01
    (st_r == ST_STOPPED && !sco_r[`BIT_OSC_RUN_IN_STOP] && st_nxt == ST_STOPPED) |=> !half_rate_clk_en)
    else $error("clock runs in stop");
  half_run_a: assert property (@(posedge sys_clk) disable iff (rst) // R01
    (st_nxt != ST_STOPPED) |=> half_rate_clk_en)
    else $error("half-rate clock off outside stop");

  // checks: static option levels
  wd_level_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
    wr_so |-> ##2 watchdog_disable == $past(hwdata[`BIT_WATCHDOG_DISABLE], 2))
    else $error("watchdog bit");
  lv_power_a: assert property (@(posedge sys_clk) disable iff (rst) // R03
    wr_so |-> ##2 lowvolt_power_off == $past(hwdata[`BIT_LOWVOLT_POWER_OFF], 2))
    else $error("lv power bit");
  awu_sel_a: assert property (@(posedge sys_clk) disable iff (rst) // R02
    1'b1 |=> awu_period_sel == $past(so_r[`BIT_WATCHDOG_RATE_SEL]) &&
      awu_clk_sel == $past(awu_r[`BIT_AWU_CLK_SEL]))
    else $error("wakeup period select level");
  pin_enable_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
    1'b1 |=> reset_pin_enable == $past(sco_r[`BIT_RESET_PIN_ENABLE]))
    else $error("reset pin enable level");

  // checks: wakeup interrupt request
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    (!wakeup_irq_req && !awu_r[`BIT_WAKEUP_IRQ_EN]) |=> !wakeup_irq_req)
    else $error("irq set while off");
  irq_set_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    irq_set |=> wakeup_irq_req)
    else $error("irq not latched");
  irq_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    (irq_clr && !irq_set) |=> !wakeup_irq_req)
    else $error("irq not cleared");
endmodule // system_option_config_bits

// file: system_option_config_bits_test.sv
// testbench for the system option block: register access, stop entry and recovery, reset behaviour
// assumes the design header and package are compiled first; LONG_DELAY is cut to 64 to keep the run short
`timescale 1ns/1ns
`include "sysopt_regs.svh"
module system_option_config_bits_test;
  import sysopt_pkg::*;
  localparam int LONG = 64;
  logic        sys_clk = 1'b0, rst = 1'b1, por_n = 1'b0, lvi_reset = 1'b0, wakeup_event = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, dph = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        hreadyout, hresp, osc_run_in_stop, half_rate_clk_en, awu_period_sel, awu_clk_sel;
  logic        lowvolt_power_off, lowvolt_trip_select, stop_enable, illegal_stop, watchdog_disable;
  logic        reset_pin_enable, wakeup_irq_req, core_clk_en;
  logic [31:0] exp_q[$];
  logic [7:0]  v;
  int          num_errors = 0, comparisons = 0, seed = 88, ill_cnt = 0, n;

  system_option_config_bits #(.LONG_DELAY(LONG), .SHORT_DELAY(32)) DUT (
    .sys_clk(sys_clk), .rst(rst), .por_n(por_n), .lvi_reset(lvi_reset), .wakeup_event(wakeup_event),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_run_in_stop(osc_run_in_stop), .half_rate_clk_en(half_rate_clk_en), .awu_period_sel(awu_period_sel),
    .awu_clk_sel(awu_clk_sel), .lowvolt_power_off(lowvolt_power_off), .lowvolt_trip_select(lowvolt_trip_select),
    .stop_enable(stop_enable), .illegal_stop(illegal_stop), .watchdog_disable(watchdog_disable),
    .reset_pin_enable(reset_pin_enable), .wakeup_irq_req(wakeup_irq_req), .core_clk_en(core_clk_en));

  always #5 sys_clk = ~sys_clk;

  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // address phase held until hready, then data phase held until hready again
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2; hsize <= 3'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  // bounded so a stuck recovery counter cannot hang the run
  task automatic wait_core(output int c);
    c = 0;
    while (core_clk_en !== 1'b1 && c < 5000) begin
      @(posedge sys_clk);
      c++;
    end
  endtask

  task automatic stop_exit(input logic by_lvi, input logic hr_exp, output int c);
    wr(`OFS_STOP_CONTROL, 32'h1);
    tick(4);
    chk("core_clk_en stopped", 0, core_clk_en);
    chk("half_rate_clk_en", hr_exp, half_rate_clk_en);
    if (by_lvi) lvi_reset <= 1'b1;
    else wakeup_event <= 1'b1;
    tick(2);
    lvi_reset <= 1'b0;
    wakeup_event <= 1'b0;
    wait_core(c);
    c = c + 2;
  endtask

  // read data stands for one cycle after the wait state; it is taken at the edge where hready closes the data phase
  always @(posedge sys_clk) begin
    if (dph && hreadyout === 1'b1) begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (hreadyout === 1'b1) dph <= hsel && htrans[1] && !hwrite;
    if (illegal_stop === 1'b1) ill_cnt++;
  end

  initial begin
    #500000;
    num_errors++;
    results();
  end

  initial begin
    tick(20);
    rst <= 1'b0;
    por_n <= 1'b1;
    wait_core(n);
    chk("power-on delay", 1, n >= LONG && n <= LONG + 10);
    rd(`OFS_STOP_CLOCK_OPTION, 32'h0);
    rd(`OFS_SYSTEM_OPTION, 32'h0);
    rd(`OFS_AWU_CONTROL, 32'h0);
    wr(32'h20, 32'hFF);
    rd(32'h20, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 8'h2F;
      wr(`OFS_SYSTEM_OPTION, {24'h0, v});
      tick(2);
      chk("awu_period_sel", v[0], awu_period_sel);
      chk("lowvolt_power_off", v[1], lowvolt_power_off);
      chk("lowvolt_trip_select", v[2], lowvolt_trip_select);
      chk("stop_enable", v[4], stop_enable);
      chk("watchdog_disable", v[5], watchdog_disable);
      rd(`OFS_SYSTEM_OPTION, {24'h0, v});
    end
    ill_cnt = 0;
    wr(`OFS_STOP_CONTROL, 32'h1);
    tick(3);
    chk("illegal_stop pulses", 1, ill_cnt);
    chk("core_clk_en kept", 1, core_clk_en);
    wr(`OFS_STOP_CLOCK_OPTION, 32'h2);
    wr(`OFS_SYSTEM_OPTION, 32'h18);
    tick(2);
    chk("reset_pin_enable", 1, reset_pin_enable);
    chk("osc_run_in_stop", 0, osc_run_in_stop);
    stop_exit(1'b0, 1'b0, n);
    chk("short recovery", 1, n >= 32 && n <= 40);
    chk("irq masked", 0, wakeup_irq_req);
    wr(`OFS_STOP_CLOCK_OPTION, 32'h1);
    wr(`OFS_AWU_CONTROL, 32'h3);
    tick(2);
    chk("awu_clk_sel", 1, awu_clk_sel);
    chk("reset_pin_enable off", 0, reset_pin_enable);
    stop_exit(1'b0, 1'b1, n);
    chk("short recovery again", 1, n >= 32 && n <= 40);
    chk("irq latched", 1, wakeup_irq_req);
    wr(`OFS_AWU_CONTROL, 32'h2);
    tick(2);
    chk("irq cleared", 0, wakeup_irq_req);
    stop_exit(1'b1, 1'b1, n);
    chk("low-voltage exit delay", 1, n >= LONG && n <= LONG + 10);
    wr(`OFS_SYSTEM_OPTION, 32'h4);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rd(`OFS_SYSTEM_OPTION, 32'h4);
    por_n <= 1'b0;
    tick(8);
    chk("trip cleared by power-on", 0, lowvolt_trip_select);
    por_n <= 1'b1;
    wait_core(n);
    chk("second power-on delay", 1, n >= LONG && n <= LONG + 10);
    tick(2);
    results();
  end
endmodule // system_option_config_bits_test
